// >>> src/nibble_swap_and_dir_load_exec.sv
// Executor for subtract, nibble exchange and legacy direction-load instructions
// How it works
// - Nibble exchange swaps register halves into destination; flags untouched.
// - Seven-bit index addresses registers 0..127; target bit picks accumulator or register.
// - With target bit set, result overwrites source register; accumulator unchanged.
// - One word, one cycle: Q1 decode, Q2 read, Q3 process, Q4 write.
// - Direction-load copies accumulator into direction register 5..7; flags untouched.
`timescale 1ns/1ps
`default_nettype none
module nibble_swap_and_dir_load_exec
  import exec_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // Instruction fetch, sampled at Q1
  input  wire logic [WORD_W-1:0] instr_word,
  // Register file read port
  output logic       [ADDR_W-1:0] rf_read_addr,
  input  wire logic [DATA_W-1:0] rf_read_data,
  // Register file write port
  output logic       [ADDR_W-1:0] rf_write_addr,
  output logic       [DATA_W-1:0] rf_write_data,
  output logic                    rf_write_en,
  // Accumulator and flags
  output logic       [DATA_W-1:0] accumulator,
  output logic                    borrow_not_flag,
  output logic                    half_borrow_flag,
  output logic                    result_null_flag,
  // Pin direction registers 5, 6, 7
  output logic       [DATA_W-1:0] pin_direction_register_5,
  output logic       [DATA_W-1:0] pin_direction_register_6,
  output logic       [DATA_W-1:0] pin_direction_register_7,
  // Phase indicator
  output logic       [1:0]        exec_phase
);
  logic [1:0]        phase;
  logic              cycle_start;
  op_type            op;
  logic              to_reg;
  logic [ADDR_W-1:0] index;
  logic [DIRSEL_W-1:0] dir_sel;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] next_result;
  logic [DATA_W:0]   diff;
  logic [4:0]        low_diff;

  function automatic op_type decode(input logic [WORD_W-1:0] w);
    op_type o;
    o = OP_NONE;
    if (w[OPC_HI:OPC_LO] == OPC_SUB) begin
      o = OP_SUB;
    end else if (w[OPC_HI:OPC_LO] == OPC_SWAP) begin
      o = OP_SWAP;
    end else if (w[WORD_W-1:DIRSEL_W] == OPC_DIRLOAD
                 && w[DIRSEL_W-1:0] >= DIR_MIN && w[DIRSEL_W-1:0] <= DIR_MAX) begin
      o = OP_DIR;
    end
    return o;
  endfunction

  // Q4 write-back of the two results that may go to either destination
  function automatic logic writes_dest(input op_type o, input logic [1:0] ph);
    return ph == PH_Q4 && (o == OP_SUB || o == OP_SWAP);
  endfunction

  // Q4 direction load aimed at one of the three slots
  function automatic logic dir_hit(input op_type o, input logic [1:0] ph,
                                   input logic [DIRSEL_W-1:0] sel,
                                   input logic [DIRSEL_W-1:0] slot);
    return ph == PH_Q4 && o == OP_DIR && sel == slot;
  endfunction

  // Exchange the upper and lower halves of a byte
  function automatic logic [DATA_W-1:0] swap_halves(input logic [DATA_W-1:0] v);
    return {v[3:0], v[7:4]};
  endfunction

  // Free-running phase counter; phase 0 takes the next word
  phase_gen u_phase (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .phase       (phase),
    .cycle_start (cycle_start)
  );

  // Phase shown one cycle late, so Q4 lines up with the visible results
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      exec_phase <= PH_Q1;
    end else begin
      exec_phase <= phase;
    end
  end

  // Q1 decode; the word is taken only at the first phase of each cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      op <= OP_NONE;
    end else if (cycle_start) begin
      op <= decode(instr_word);
    end
  end

  // Q1 operand fields
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      to_reg  <= 1'b0;
      index   <= '0;
      dir_sel <= '0;
    end else if (cycle_start) begin
      to_reg  <= instr_word[DEST_BIT];
      index   <= instr_word[ADDR_W-1:0];
      dir_sel <= instr_word[DIRSEL_W-1:0];
    end
  end

  // Q2 read: the address follows the word taken at Q1, so the read port
  // settles on the new register before the operand is captured
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rf_read_addr <= '0;
    end else if (cycle_start) begin
      rf_read_addr <= instr_word[ADDR_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      operand <= '0;
    end else if (phase == PH_Q2) begin
      operand <= rf_read_data;
    end
  end

  // Q3 process
  always_comb begin
    diff     = {1'b0, operand} - {1'b0, accumulator};
    low_diff = {1'b0, operand[3:0]} - {1'b0, accumulator[3:0]};
  end

  always_comb begin
    case (op)
      OP_SUB:  next_result = diff[DATA_W-1:0];
      OP_SWAP: next_result = swap_halves(operand);
      OP_DIR:  next_result = accumulator;
      default: next_result = '0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      result <= '0;
    end else if (phase == PH_Q3) begin
      result <= next_result;
    end
  end

  // Q4 register file write; the strobe is a one-cycle pulse
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rf_write_en   <= 1'b0;
      rf_write_addr <= '0;
      rf_write_data <= '0;
    end else begin
      rf_write_en <= 1'b0;
      if (writes_dest(op, phase) && to_reg) begin
        rf_write_en   <= 1'b1;
        rf_write_addr <= index;
        rf_write_data <= result;
      end
    end
  end

  // Q4 accumulator write; a register destination leaves it untouched
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      accumulator <= ACC_RESET;
    end else if (writes_dest(op, phase) && !to_reg) begin
      accumulator <= result;
    end
  end

  // Flags change only for subtract
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      borrow_not_flag  <= 1'b0;
      half_borrow_flag <= 1'b0;
      result_null_flag <= 1'b0;
    end else if (phase == PH_Q4 && op == OP_SUB) begin
      borrow_not_flag  <= ~diff[DATA_W];
      half_borrow_flag <= ~low_diff[4];
      result_null_flag <= (result == '0);
    end
  end

  // Legacy direction load, one block per register; direct writes are preferred
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_direction_register_5 <= DIR_RESET;
    end else if (dir_hit(op, phase, dir_sel, DIR_MIN)) begin
      pin_direction_register_5 <= result;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_direction_register_6 <= DIR_RESET;
    end else if (dir_hit(op, phase, dir_sel, DIR_MIN + 3'h1)) begin
      pin_direction_register_6 <= result;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pin_direction_register_7 <= DIR_RESET;
    end else if (dir_hit(op, phase, dir_sel, DIR_MAX)) begin
      pin_direction_register_7 <= result;
    end
  end
endmodule // nibble_swap_and_dir_load_exec
`default_nettype wire

// >>> src/exec_pkg.sv
// Shared constants for the nibble exchange / subtract / direction-load executor
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int WORD_W = 14;
  localparam int ADDR_W = 7;
  // Opcode fields
  localparam logic [5:0] OPC_SUB  = 6'h02;
  localparam logic [5:0] OPC_SWAP = 6'h0E;
  localparam logic [10:0] OPC_DIRLOAD = 11'h00C;  // 00 0000 0110 0 (upper 11 bits)
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int DIRSEL_W = 3;
  localparam logic [2:0] DIR_MIN = 3'h5;
  localparam logic [2:0] DIR_MAX = 3'h7;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;
  localparam logic [7:0] ACC_RESET = 8'h00;
  typedef enum logic [1:0] {OP_NONE, OP_SUB, OP_SWAP, OP_DIR} op_type;
endpackage : exec_pkg

// >>> src/phase_gen.sv
// Four-phase instruction cycle generator
`timescale 1ns/1ps
`default_nettype none
module phase_gen
  import exec_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Phase outputs
  output var  logic [1:0] phase,
  output var  logic       cycle_start
);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      phase <= PH_Q1;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  assign cycle_start = (phase == PH_Q1);
endmodule // phase_gen
`default_nettype wire

// >>> verif/reg_file_model.sv
// Register file model: combinational read, write on the strobe
`timescale 1ns/1ps
`default_nettype none
module reg_file_model (
  input  wire logic       clock,
  input  wire logic [6:0] ra,
  output logic      [7:0] rd,
  input  wire logic [6:0] wa,
  input  wire logic [7:0] wd,
  input  wire logic       we
);
  logic [7:0] mem [128];
  assign rd = mem[ra];
  always @(posedge clock) if (we) mem[wa] <= wd;
endmodule // reg_file_model
`default_nettype wire

// >>> verif/exec_chk.sv
// Port checker for the executor
`timescale 1ns/1ps
`default_nettype none
module exec_chk
  import exec_pkg::*;
(
  input wire logic clock, sys_rst, rf_write_en, borrow_not_flag, half_borrow_flag, result_null_flag,
  input wire logic [13:0] instr_word,
  input wire logic [6:0] rf_write_addr,
  input wire logic [1:0] exec_phase,
  input wire logic [7:0] rf_read_data, rf_write_data, accumulator,
  input wire logic [7:0] pin_direction_register_5, pin_direction_register_6, pin_direction_register_7
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire logic [5:0] op = exec_phase == PH_Q4 ? instr_word[13:8] : 6'h3F;
  wire logic d = instr_word[DEST_BIT];
  wire logic dl = exec_phase == PH_Q4 && instr_word[13:3] == OPC_DIRLOAD && instr_word[2:0] >= DIR_MIN;
  wire logic [7:0] nib = {rf_read_data[3:0], rf_read_data[7:4]};
  wire logic [2:0] flg = {borrow_not_flag, half_borrow_flag, result_null_flag};
  wire logic [6:0] idx = instr_word[6:0];
  wire logic [2:0] sel = instr_word[2:0];
  sequence s_exec; ##4 exec_phase == PH_Q4; endsequence
  property p_phase; exec_phase == PH_Q2 |=> exec_phase == PH_Q3 ##1 exec_phase == PH_Q4 ##1 exec_phase == PH_Q1; endproperty
  a_phase: assert property (p_phase) else $error("phase order");
  property p_pulse; rf_write_en |=> !rf_write_en [*3]; endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse");
  property p_swreg; op == OPC_SWAP && d |-> s_exec ##0 (rf_write_en && rf_write_data == nib && rf_write_addr == $past(idx, 4)); endproperty
  a_swreg: assert property (p_swreg) else $error("swap to register");
  property p_swacc; op == OPC_SWAP && !d |-> s_exec ##0 (!rf_write_en && accumulator == nib); endproperty
  a_swacc: assert property (p_swacc) else $error("swap to accumulator");
  property p_keep; op == OPC_SWAP && d |=> $stable(accumulator) [*4]; endproperty
  a_keep: assert property (p_keep) else $error("accumulator moved");
  property p_flags; op == OPC_SWAP || dl |=> $stable(flg) [*4]; endproperty
  a_flags: assert property (p_flags) else $error("flags moved");
  property p_dir; dl |-> s_exec ##0 accumulator == ($past(sel, 4) == 3'h5 ? pin_direction_register_5 :
    $past(sel, 4) == 3'h6 ? pin_direction_register_6 : pin_direction_register_7); endproperty
  a_dir: assert property (p_dir) else $error("direction load");
  property p_sub; op == OPC_SUB && d |-> s_exec ##0 (rf_write_en && rf_write_data == rf_read_data - accumulator &&
    flg == {rf_read_data >= accumulator, rf_read_data[3:0] >= accumulator[3:0], rf_write_data == 8'h00}); endproperty
  a_sub: assert property (p_sub) else $error("subtract");
  property p_subacc; op == OPC_SUB && !d |-> s_exec ##0
    (!rf_write_en && accumulator == rf_read_data - $past(accumulator, 4)); endproperty
  a_subacc: assert property (p_subacc) else $error("subtract to accumulator");
endmodule // exec_chk
bind nibble_swap_and_dir_load_exec exec_chk chk_i (.clock, .sys_rst, .rf_write_en, .borrow_not_flag, .half_borrow_flag,
  .result_null_flag, .instr_word, .rf_write_addr, .exec_phase, .rf_read_data, .rf_write_data, .accumulator,
  .pin_direction_register_5, .pin_direction_register_6, .pin_direction_register_7);
`default_nettype wire

// >>> verif/nibble_swap_and_dir_load_exec_test.sv
// Self-checking bench for the executor
`timescale 1ns/1ps
`default_nettype none
module nibble_swap_and_dir_load_exec_test;
  import exec_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, we, bn, hb, rn;
  logic [13:0] iw = 14'h0000;
  logic [6:0] ra, wa;
  logic [7:0] rd, wd, acc, d5, d6, d7;
  logic [1:0] ph;
  int failures = 0, checks_done = 0;
  nibble_swap_and_dir_load_exec uut (.clock, .sys_rst, .instr_word(iw), .rf_read_addr(ra), .rf_read_data(rd),
    .rf_write_addr(wa), .rf_write_data(wd), .rf_write_en(we), .accumulator(acc), .borrow_not_flag(bn),
    .half_borrow_flag(hb), .result_null_flag(rn), .pin_direction_register_5(d5),
    .pin_direction_register_6(d6), .pin_direction_register_7(d7), .exec_phase(ph));
  reg_file_model rf (.clock, .ra, .rd, .wa, .wd, .we);
  initial forever #4 clock = ~clock;
  task chk(string n, logic [7:0] s, logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Word is held for its take edge only, so it never repeats
  task run(logic [13:0] w);
    while (ph !== PH_Q3) @(negedge clock);
    @(posedge clock) iw <= w;
    @(posedge clock) iw <= 14'h0000;
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask
  task t_sub;
    logic [7:0] v, r;
    rf.mem[9] = 8'h20;
    run({OPC_SWAP, 1'b0, 7'h09});
    for (int i = 0; i < 3; i++) begin
      v = 8'h01 + 8'(i);
      r = v - 8'h02;
      rf.mem[10+i] = v;
      run({OPC_SUB, 1'b1, 7'(10 + i)});
      chk("diff", wd, r);
      chk("flags", {bn, hb, rn}, {v >= 8'h02, v[3:0] >= 4'h2, r == 8'h00});
      chk("acc", acc, 8'h02);
    end
    rf.mem[13] = 8'h05;
    run({OPC_SUB, 1'b0, 7'h0D});
    chk("acc", acc, 8'h03);
    chk("wen", we, 8'h00);
    chk("flags", {bn, hb, rn}, 8'h06);
    $display("sub done");
  endtask
  task t_swap;
    rf.mem[127] = 8'hA5;
    rf.mem[0] = 8'h3C;
    run({OPC_SWAP, 1'b0, 7'h7F});
    chk("acc", acc, 8'h5A);
    chk("wen", we, 8'h00);
    chk("raddr", ra, 8'h7F);
    run({OPC_SWAP, 1'b1, 7'h00});
    chk("wdata", wd, 8'hC3);
    chk("wen", we, 8'h01);
    chk("waddr", wa, 8'h00);
    chk("acc", acc, 8'h5A);
    chk("flags", {bn, hb, rn}, 8'h06);
    $display("swap done");
  endtask
  task t_dir;
    logic [7:0] e [5:7];
    e = '{default: DIR_RESET};
    for (int f = 0; f < 8; f++) begin
      run({OPC_DIRLOAD, 3'(f)}); // Legacy form exercised on purpose
      if (f >= 5) e[f] = 8'h5A;
      chk("dir5", d5, e[5]);
      chk("dir6", d6, e[6]);
      chk("dir7", d7, e[7]);
    end
    $display("dir done");
  endtask
  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    t_sub;
    t_swap;
    t_dir;
    conclude;
  end
  initial begin
    repeat (600) @(posedge clock);
    failures++;
    conclude;
  end
endmodule // nibble_swap_and_dir_load_exec_test
`default_nettype wire
